/* src/ccs_busoff_recover.sv */
`timescale 1ns/1ps
// Bus-off entry and recovery by counting runs of recessive bits
module ccs_busoff_recover #(
  parameter int RUN_LEN = ccs_pkg::CCS_RECESSIVE_RUN,
  parameter int RUNS = ccs_pkg::CCS_RECOVERY_RUNS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic overflow_i,
  input wire logic bit_tick_i,
  input wire logic rx_bit_i,
  output logic bus_off_o,
  output logic tec_clear_o
);
  import ccs_pkg::*;

  typedef struct packed {
    ccs_bo_state_e state;
    logic prev_over;
    logic [$clog2(RUN_LEN+1)-1:0] run;
    logic [$clog2(RUNS+1)-1:0] runs;
    logic clear;
  } ccs_bo_s;

  ccs_bo_s st_reg;
  ccs_bo_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.clear = 1'b0;
    st_next.prev_over = overflow_i;
    case (st_reg.state)
      CCS_BO_ACTIVE:
      begin
        // Edge only, so a counter still high after clearing does not re-enter
        if (overflow_i && !st_reg.prev_over)
        begin
          st_next.state = CCS_BO_OFF;
          st_next.run = '0;
          st_next.runs = '0;
        end
      end
      CCS_BO_OFF:
      begin
        if (bit_tick_i)
        begin
          if (!rx_bit_i)
          begin
            st_next.run = '0;
          end
          else if (st_reg.run == ($bits(st_reg.run))'(RUN_LEN - 1))
          begin
            st_next.run = '0;
            if (st_reg.runs == ($bits(st_reg.runs))'(RUNS - 1))
            begin
              st_next.state = CCS_BO_ACTIVE;
              st_next.clear = 1'b1;
            end
            else
            begin
              st_next.runs = st_reg.runs + 1'b1;
            end
          end
          else
          begin
            st_next.run = st_reg.run + 1'b1;
          end
        end
      end
      default:
      begin
        st_next.state = CCS_BO_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus_off_o = (st_reg.state == CCS_BO_OFF);
  assign tec_clear_o = st_reg.clear;

endmodule : ccs_busoff_recover

/* src/ccs_comm_status.sv */
`timescale 1ns/1ps
// Functional notes
// - In the two-buffer mode the top status bit latches an overflow of receive buffer zero until software clears it.
// - In the two-buffer mode the second status bit latches an overflow of receive buffer one until cleared.
// - In the enhanced legacy mode the top status bit always reads zero.
// - In the FIFO mode the top status bit reads one while the receive FIFO holds at least one message.
// - In enhanced legacy and FIFO modes the second bit latches an overflow of any receive buffer until cleared.
// - The bus-off flag is high exactly while the transmit error count is above 255.
// - The transmit error-passive flag is high exactly while the transmit error count is above 127.
// - A read-only receive error-passive flag reflects the receive error-passive region.
// - The receive warning flag is high only while the receive error count is above 95 and at most 127.
// - The combined warning flag is the OR of the receive and transmit warning flags.
// - Bus-off is entered on counter overflow and the counter is cleared after 128 runs of 11 recessive bits.
// - Any error condition sets one error interrupt flag, and the status register tells which one.
module ccs_comm_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ccs_pkg::CCS_ERR_CNT_W-1:0] tec_i,
  input wire logic [ccs_pkg::CCS_ERR_CNT_W-1:0] rec_i,
  input wire logic rx_buf0_ovf_i,
  input wire logic rx_buf1_ovf_i,
  input wire logic rx_fifo_not_empty_i,
  input wire logic bit_tick_i,
  input wire logic can_rx_i,
  output logic irq_o,
  output logic bus_off_o,
  output logic tec_clear_o,
  output logic [ccs_pkg::CCS_MODE_W-1:0] mode_o
);
  import ccs_pkg::*;

  typedef struct packed {
    ccs_mode_e mode;
    logic rx_meta;
    logic rx_sync;
    logic ovf_zero;
    logic ovf_one;
    logic ovf_any;
    logic [7:0] comm_status;
    logic [CCS_IRQ_W-1:0] irq_status;
    logic [CCS_IRQ_W-1:0] irq_mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic bus_off;
    logic tec_clear;
  } ccs_top_s;

  ccs_top_s st_reg;
  ccs_top_s st_next;

  logic tx_warn;
  logic tx_passive;
  logic tx_over;
  logic rx_warn;
  logic rx_passive;
  logic recov_bus_off;
  logic recov_clear;

  logic bus_access;
  logic wr_low;
  logic [7:0] wr_byte;
  logic [7:0] status_now;
  logic [4:0] err_flags;
  logic [4:0] err_rise;
  logic [CCS_IRQ_W-1:0] irq_set;
  logic clr_top;
  logic clr_second;
  logic wr_status;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_mask;

  ccs_err_level #(
    .CNT_W(CCS_ERR_CNT_W)
  ) u_tx_level (
    .count_i(tec_i),
    .warn_o(tx_warn),
    .passive_o(tx_passive),
    .over_o(tx_over)
  );

  ccs_err_level #(
    .CNT_W(CCS_ERR_CNT_W)
  ) u_rx_level (
    .count_i(rec_i),
    .warn_o(rx_warn),
    .passive_o(rx_passive),
    .over_o()
  );

  ccs_busoff_recover #(
    .RUN_LEN(CCS_RECESSIVE_RUN),
    .RUNS(CCS_RECOVERY_RUNS)
  ) u_recover (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .overflow_i(tx_over),
    .bit_tick_i(bit_tick_i),
    .rx_bit_i(st_reg.rx_sync),
    .bus_off_o(recov_bus_off),
    .tec_clear_o(recov_clear)
  );

  // Classic Wishbone slave: one wait state, ack pulses for one cycle
  always_comb
  begin
    bus_access = wb_cyc_i && wb_stb_i && !st_reg.ack;
    wr_low = bus_access && wb_we_i && wb_sel_i[0];
    wr_byte = wb_dat_i[7:0];
  end

  // Address decode of the single-byte writes
  always_comb
  begin
    wr_status = 1'b0;
    wr_ctrl = 1'b0;
    wr_irq = 1'b0;
    wr_mask = 1'b0;
    if (wb_adr_i == CCS_OFF_COMM_STATUS)
    begin
      wr_status = wr_low;
    end
    else if (wb_adr_i == CCS_OFF_CONTROL)
    begin
      wr_ctrl = wr_low;
    end
    else if (wb_adr_i == CCS_OFF_IRQ_STATUS)
    begin
      wr_irq = wr_low;
    end
    else if (wb_adr_i == CCS_OFF_IRQ_MASK)
    begin
      wr_mask = wr_low;
    end
  end

  // Error flags as the counters stand now
  always_comb
  begin
    err_flags = 5'h00;
    err_flags[4] = tx_over;
    err_flags[3] = tx_passive;
    err_flags[2] = rx_passive;
    err_flags[1] = tx_warn;
    err_flags[0] = rx_warn;
    err_rise = err_flags & ~st_reg.comm_status[CCS_BIT_BUS_OFF:CCS_BIT_RX_WARN];
  end

  // Write-one-to-clear of the overflow flags
  always_comb
  begin
    clr_top = 1'b0;
    clr_second = 1'b0;
    if (wr_status)
    begin
      clr_top = wr_byte[CCS_BIT_TOP] && (st_reg.mode == CCS_MODE_LEGACY);
      clr_second = wr_byte[CCS_BIT_SECOND];
    end
  end

  // Status view, selected by the operating mode
  always_comb
  begin
    status_now = CCS_STATUS_RESET;
    case (st_reg.mode)
      CCS_MODE_LEGACY:
      begin
        status_now[CCS_BIT_TOP] = st_reg.ovf_zero;
        status_now[CCS_BIT_SECOND] = st_reg.ovf_one;
      end
      CCS_MODE_ENHANCED:
      begin
        status_now[CCS_BIT_TOP] = 1'b0;
        status_now[CCS_BIT_SECOND] = st_reg.ovf_any;
      end
      CCS_MODE_FIFO:
      begin
        status_now[CCS_BIT_TOP] = rx_fifo_not_empty_i;
        status_now[CCS_BIT_SECOND] = st_reg.ovf_any;
      end
      default:
      begin
        status_now[CCS_BIT_TOP] = 1'b0;
        status_now[CCS_BIT_SECOND] = 1'b0;
      end
    endcase
    status_now[CCS_BIT_BUS_OFF:CCS_BIT_RX_WARN] = err_flags;
    status_now[CCS_BIT_ANY_WARN] = rx_warn || tx_warn;
  end

  // Interrupt sources
  always_comb
  begin
    irq_set = '0;
    irq_set[CCS_IRQ_RX_OVF] = rx_buf0_ovf_i || rx_buf1_ovf_i;
    irq_set[CCS_IRQ_RX_WARN] = err_rise[0];
    irq_set[CCS_IRQ_TX_WARN] = err_rise[1];
    irq_set[CCS_IRQ_RX_PASSIVE] = err_rise[2];
    irq_set[CCS_IRQ_TX_PASSIVE] = err_rise[3];
    irq_set[CCS_IRQ_BUS_OFF] = err_rise[4];
    irq_set[CCS_IRQ_ERROR] = |err_rise || irq_set[CCS_IRQ_RX_OVF];
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.rx_meta = can_rx_i;
    st_next.rx_sync = st_reg.rx_meta;
    st_next.ack = bus_access;
    st_next.bus_off = recov_bus_off;
    st_next.tec_clear = recov_clear;
    st_next.comm_status = status_now;

    // Overflow flags: a new overflow wins over a clear in the same cycle
    if (clr_top)
    begin
      st_next.ovf_zero = 1'b0;
    end
    if (clr_second)
    begin
      st_next.ovf_one = 1'b0;
      st_next.ovf_any = 1'b0;
    end
    if (rx_buf0_ovf_i && (st_reg.mode == CCS_MODE_LEGACY))
    begin
      st_next.ovf_zero = 1'b1;
    end
    if (rx_buf1_ovf_i && (st_reg.mode == CCS_MODE_LEGACY))
    begin
      st_next.ovf_one = 1'b1;
    end
    if ((rx_buf0_ovf_i || rx_buf1_ovf_i) && (st_reg.mode != CCS_MODE_LEGACY))
    begin
      st_next.ovf_any = 1'b1;
    end

    // Register writes
    if (wr_ctrl)
    begin
      st_next.mode = ccs_mode_e'(wr_byte[CCS_MODE_LSB +: CCS_MODE_W]);
      // Unused encoding falls back to the two-buffer mode
      if (wr_byte[CCS_MODE_LSB +: CCS_MODE_W] > CCS_MODE_W'(CCS_MODE_FIFO))
      begin
        st_next.mode = CCS_MODE_LEGACY;
      end
    end
    if (wr_mask)
    begin
      st_next.irq_mask = wr_byte[CCS_IRQ_W-1:0];
    end

    // Sticky interrupt status, set wins over write-one clear
    st_next.irq_status = st_reg.irq_status;
    if (wr_irq)
    begin
      st_next.irq_status = st_reg.irq_status & ~wr_byte[CCS_IRQ_W-1:0];
    end
    st_next.irq_status = st_next.irq_status | irq_set;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);

    // Read data; unmapped offsets read zero but still acknowledge
    st_next.dat = CCS_DATA_ZERO;
    if (bus_access && !wb_we_i)
    begin
      if (wb_adr_i == CCS_OFF_COMM_STATUS)
      begin
        st_next.dat[7:0] = st_reg.comm_status;
      end
      else if (wb_adr_i == CCS_OFF_CONTROL)
      begin
        st_next.dat[CCS_MODE_LSB +: CCS_MODE_W] = st_reg.mode;
      end
      else if (wb_adr_i == CCS_OFF_IRQ_STATUS)
      begin
        st_next.dat[CCS_IRQ_W-1:0] = st_reg.irq_status;
      end
      else if (wb_adr_i == CCS_OFF_IRQ_MASK)
      begin
        st_next.dat[CCS_IRQ_W-1:0] = st_reg.irq_mask;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign irq_o = st_reg.irq;
  assign bus_off_o = st_reg.bus_off;
  assign tec_clear_o = st_reg.tec_clear;
  assign mode_o = st_reg.mode;

endmodule : ccs_comm_status

/* src/ccs_err_level.sv */
`timescale 1ns/1ps
// Classifies one error counter into warning and passive regions
module ccs_err_level #(
  parameter int CNT_W = ccs_pkg::CCS_ERR_CNT_W
) (
  input wire logic [CNT_W-1:0] count_i,
  output logic warn_o,
  output logic passive_o,
  output logic over_o
);
  import ccs_pkg::*;

  always_comb
  begin
    warn_o = (count_i > CNT_W'(CCS_WARN_LIMIT)) && (count_i <= CNT_W'(CCS_PASSIVE_LIMIT));
    passive_o = count_i > CNT_W'(CCS_PASSIVE_LIMIT);
    over_o = count_i > CNT_W'(CCS_BUS_OFF_LIMIT);
  end

endmodule : ccs_err_level

/* src/ccs_pkg.sv */
package ccs_pkg;

  // Register byte offsets
  localparam logic [7:0] CCS_OFF_COMM_STATUS = 8'h00;
  localparam logic [7:0] CCS_OFF_CONTROL = 8'h04;
  localparam logic [7:0] CCS_OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] CCS_OFF_IRQ_MASK = 8'h0c;

  // Communication status field positions
  localparam int CCS_BIT_TOP = 7;
  localparam int CCS_BIT_SECOND = 6;
  localparam int CCS_BIT_BUS_OFF = 5;
  localparam int CCS_BIT_TX_PASSIVE = 4;
  localparam int CCS_BIT_RX_PASSIVE = 3;
  localparam int CCS_BIT_TX_WARN = 2;
  localparam int CCS_BIT_RX_WARN = 1;
  localparam int CCS_BIT_ANY_WARN = 0;

  // Interrupt status field positions
  localparam int CCS_IRQ_RX_OVF = 0;
  localparam int CCS_IRQ_RX_WARN = 1;
  localparam int CCS_IRQ_TX_WARN = 2;
  localparam int CCS_IRQ_RX_PASSIVE = 3;
  localparam int CCS_IRQ_TX_PASSIVE = 4;
  localparam int CCS_IRQ_BUS_OFF = 5;
  localparam int CCS_IRQ_ERROR = 6;
  localparam int CCS_IRQ_W = 7;

  // Control register: operating mode field
  localparam int CCS_MODE_LSB = 0;
  localparam int CCS_MODE_W = 2;

  // Error counter widths and limits
  localparam int CCS_ERR_CNT_W = 9;
  localparam logic [8:0] CCS_WARN_LIMIT = 9'h05f;
  localparam logic [8:0] CCS_PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] CCS_BUS_OFF_LIMIT = 9'h0ff;

  // Bus-off recovery counts
  localparam int CCS_RECESSIVE_RUN = 11;
  localparam int CCS_RECOVERY_RUNS = 128;

  localparam logic [7:0] CCS_STATUS_RESET = 8'h00;
  localparam logic [31:0] CCS_DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    CCS_MODE_LEGACY,
    CCS_MODE_ENHANCED,
    CCS_MODE_FIFO
  } ccs_mode_e;

  typedef enum logic {
    CCS_BO_ACTIVE,
    CCS_BO_OFF
  } ccs_bo_state_e;

endpackage : ccs_pkg

/* tb/ccs_can_node_model.sv */
`timescale 1ns/1ps
// Other bus nodes: idle bus stays recessive, bit ticks only while the bus runs
module ccs_can_node_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic bit_tick_o,
  output logic can_rx_o
);
  logic [1:0] div_reg;
  always_ff @(posedge clk_i)
  begin
    div_reg <= (rst_i || !run_i) ? 2'h0 : div_reg + 2'h1;
  end
  assign bit_tick_o = run_i && div_reg == 2'h3;
  assign can_rx_o = 1'b1;
endmodule : ccs_can_node_model

/* tb/ccs_comm_status_assertions.sv */
`timescale 1ns/1ps
module ccs_comm_status_assertions
  import ccs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [8:0] tec_i,
  input wire logic [8:0] rec_i,
  input wire logic rx_fifo_not_empty_i,
  input wire logic bus_off_o,
  input wire logic tec_clear_o,
  input wire logic [1:0] mode_o
);
  logic rd_q;
  logic [8:0] t1, t2, r1, r2;
  // Register value reflects counters two cycles before the ack
  always_ff @(posedge clk_i)
  begin
    rd_q <= !rst_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == CCS_OFF_COMM_STATUS;
    t1 <= tec_i;
    t2 <= t1;
    r1 <= rec_i;
    r2 <= r1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_s;
    wb_ack_o && rd_q;
  endsequence
  sequence tec_over_s;
    $rose(tec_i > 9'd255) && !bus_off_o;
  endsequence
  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse after request");
  bus_off_flag_a: assert property (rd_s |-> wb_dat_o[5] == (t2 > 9'd255))
    else $error("bus-off flag wrong");
  tx_passive_a: assert property (rd_s |-> wb_dat_o[4] == (t2 > 9'd127))
    else $error("tx passive flag wrong");
  rx_passive_a: assert property (rd_s |-> wb_dat_o[3] == (r2 > 9'd127))
    else $error("rx passive flag wrong");
  tx_warn_a: assert property (rd_s |-> wb_dat_o[2] == (t2 > 9'd95 && t2 <= 9'd127))
    else $error("tx warning flag wrong");
  rx_warn_a: assert property (rd_s |-> wb_dat_o[1] == (r2 > 9'd95 && r2 <= 9'd127))
    else $error("rx warning flag wrong");
  any_warn_a: assert property (rd_s |-> wb_dat_o[0] == (wb_dat_o[1] | wb_dat_o[2]))
    else $error("combined warning flag wrong");
  busoff_entry_a: assert property (tec_over_s |-> ##[1:3] bus_off_o)
    else $error("bus-off not entered");
  // Clear pulse and leaving bus-off are registered in the same cycle
  tec_clear_a: assert property (tec_clear_o |-> !bus_off_o && $past(bus_off_o) ##1 !tec_clear_o)
    else $error("recovery end wrong");
  top_zero_a: assert property (rd_s ##0 (mode_o == 2'h1) |-> !wb_dat_o[7])
    else $error("top bit not zero");
  fifo_flag_a: assert property (rd_s ##0 (mode_o == 2'h2) |-> wb_dat_o[7] == $past(rx_fifo_not_empty_i, 2))
    else $error("fifo flag wrong");
endmodule : ccs_comm_status_assertions

bind ccs_comm_status ccs_comm_status_assertions u_ccs_comm_status_assertions (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tec_i(tec_i), .rec_i(rec_i), .rx_fifo_not_empty_i(rx_fifo_not_empty_i),
  .bus_off_o(bus_off_o), .tec_clear_o(tec_clear_o), .mode_o(mode_o));

/* tb/ccs_comm_status_tb.sv */
`timescale 1ns/1ps
module ccs_comm_status_tb;
  import ccs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic ack, tick, rx, irq, bus_off, tec_clr;
  logic [8:0] tec = 9'h000;
  logic [8:0] rec = 9'h000;
  logic ovf0 = 1'b0;
  logic ovf1 = 1'b0;
  logic fifo = 1'b0;
  logic run = 1'b0;
  logic [1:0] mode;
  logic [8:0] tab [6] = '{9'd95, 9'd96, 9'd127, 9'd128, 9'd255, 9'd256};
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int ticks = 0;
  always #5 clk_i = ~clk_i;
  ccs_comm_status u_ccs_comm_status (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tec_i(tec), .rec_i(rec),
    .rx_buf0_ovf_i(ovf0), .rx_buf1_ovf_i(ovf1), .rx_fifo_not_empty_i(fifo), .bit_tick_i(tick), .can_rx_i(rx),
    .irq_o(irq), .bus_off_o(bus_off), .tec_clear_o(tec_clr), .mode_o(mode));
  ccs_can_node_model u_ccs_can_node_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .bit_tick_o(tick),
    .can_rx_o(rx));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the bench timeout ends a hung cycle
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    check(nm, e, rd);
  endtask : rd_chk
  // Status register lags its inputs, so let changes settle first
  task automatic pulse(input logic one);
    if (one)
      ovf1 <= 1'b1;
    else
      ovf0 <= 1'b1;
    @(posedge clk_i);
    ovf0 <= 1'b0;
    ovf1 <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse
  function automatic logic [31:0] exp_err(input logic [8:0] t, input logic [8:0] r);
    logic tw, rw;
    tw = t > 9'd95 && t <= 9'd127;
    rw = r > 9'd95 && r <= 9'd127;
    return {26'h0, t > 9'd255, t > 9'd127, r > 9'd127, tw, rw, tw | rw};
  endfunction : exp_err
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++)
      rd_chk(8'(i * 4), 32'h0, "reset_value");
    for (int i = 0; i < 6; i++)
    begin
      tec <= tab[i];
      rec <= tab[5 - i];
      repeat (3) @(posedge clk_i);
      rd_chk(CCS_OFF_COMM_STATUS, exp_err(tab[i], tab[5 - i]), "err");
    end
    check("bus_off", 32'h1, {31'h0, bus_off});
    rd_chk(CCS_OFF_IRQ_STATUS, 32'h7e, "err_irq");
    run <= 1'b1;
    // Every bit tick is recessive, so the count must equal the full recovery
    while (tec_clr !== 1'b1)
    begin
      @(posedge clk_i);
      ticks += int'(tick);
    end
    check("tec_clear", 32'h1, {31'h0, tec_clr});
    check("recovery_ticks", 32'(CCS_RECESSIVE_RUN * CCS_RECOVERY_RUNS), 32'(ticks));
    tec <= 9'h000;
    rec <= 9'h000;
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("bus_off_end", 32'h0, {31'h0, bus_off});
    rd_chk(CCS_OFF_COMM_STATUS, 32'h0, "err_clear");
    wb(1'b1, CCS_OFF_IRQ_STATUS, 32'hff, 4'h1);
    pulse(1'b0);
    check("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, CCS_OFF_IRQ_MASK, 32'h01, 4'h1);
    repeat (2) @(posedge clk_i);
    check("irq", 32'h1, {31'h0, irq});
    rd_chk(CCS_OFF_IRQ_STATUS, 32'h41, "irq_src");
    pulse(1'b1);
    rd_chk(CCS_OFF_COMM_STATUS, 32'hc0, "ovf_both");
    wb(1'b1, CCS_OFF_COMM_STATUS, 32'h80, 4'h1);
    rd_chk(CCS_OFF_COMM_STATUS, 32'h40, "ovf0_clr");
    wb(1'b1, CCS_OFF_COMM_STATUS, 32'h40, 4'h0);
    rd_chk(CCS_OFF_COMM_STATUS, 32'h40, "ovf1_held");
    wb(1'b1, CCS_OFF_COMM_STATUS, 32'h40, 4'h1);
    wb(1'b1, CCS_OFF_IRQ_STATUS, 32'h41, 4'h1);
    rd_chk(CCS_OFF_COMM_STATUS, 32'h0, "ovf1_clr");
    check("irq_off", 32'h0, {31'h0, irq});
    wb(1'b1, CCS_OFF_CONTROL, 32'h1, 4'h1);
    check("mode_o", 32'h1, {30'h0, mode});
    fifo <= 1'b1;
    pulse(1'b0);
    rd_chk(CCS_OFF_COMM_STATUS, 32'h40, "mode1");
    wb(1'b1, CCS_OFF_CONTROL, 32'h2, 4'h1);
    rd_chk(CCS_OFF_COMM_STATUS, 32'hc0, "mode2");
    fifo <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(CCS_OFF_COMM_STATUS, 32'h40, "fifo_empty");
    wb(1'b1, CCS_OFF_COMM_STATUS, 32'h40, 4'h1);
    rd_chk(CCS_OFF_COMM_STATUS, 32'h0, "mode2_clr");
    wb(1'b1, CCS_OFF_CONTROL, 32'h3, 4'h1);
    rd_chk(CCS_OFF_CONTROL, 32'h0, "mode3");
    wb(1'b1, 8'h10, 32'hff, 4'h1);
    rd_chk(8'h10, 32'h0, "unmapped");
    report_and_stop();
  end
endmodule : ccs_comm_status_tb
